// ### hw/asrc_host.v
// host controller that runs read and write cycles on an asynchronous static memory
`timescale 1ns/100ps
`include "asrc_consts.vh"

// Summary of operation
// - write strobe stays high during reads
// - read data sampled after access time; cycles spaced
// - address set on the same edge that select falls
// - select low long enough; writes spaced
// - address valid long before write end
// - write never starts before address valid
// - write pulse held minimum width
// - recovery margin met after strobe rise
// - write data valid before write end
// - data held after strobe rise
// - address changes only with strobe high
// - host drives data only with enable high
module asrc_host #(
  parameter integer ADDR_W     = `ASRC_ADDR_W,
  parameter integer DATA_W     = `ASRC_DATA_W,
  parameter integer READ_CYC   = `ASRC_CYC_UP(`ASRC_T_READ_CYCLE_NS),
  parameter integer WPULSE_CYC = `ASRC_CYC_UP(`ASRC_T_ADDR_TO_END_NS),
  parameter integer RECOV_CYC  = `ASRC_CYC_UP(`ASRC_T_RELEASE_NS)
) (
  input  wire              i_core_clk,
  input  wire              i_rstn,
  input  wire              i_clk_en,
  input  wire              i_req_valid,
  input  wire              i_req_write,
  input  wire [ADDR_W-1:0] i_req_addr,
  input  wire [DATA_W-1:0] i_req_wdata,
  output wire              o_req_ready,
  output reg               o_rsp_valid,
  output reg  [DATA_W-1:0] o_rsp_rdata,
  output reg  [ADDR_W-1:0] o_mem_addr,
  output reg               o_mem_sel_n,
  output reg               o_mem_oe_n,
  output reg               o_mem_we_n,
  input  wire [DATA_W-1:0] i_mem_dq,
  output reg  [DATA_W-1:0] o_mem_dq,
  output reg               o_mem_dq_oe
);

  // ****************************************
  // states and counters
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RD    = 3'h1;
  localparam [2:0] ST_WR    = 3'h2;
  localparam [2:0] ST_WHOLD = 3'h3;
  localparam [2:0] ST_RECOV = 3'h4;

  localparam integer CNT_W = 8;
  localparam [CNT_W-1:0] RD_LAST  = READ_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] WR_LAST  = WPULSE_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] REC_LAST = RECOV_CYC[CNT_W-1:0];

  reg [2:0]       state_q;
  reg [CNT_W-1:0] cnt_q;

  assign o_req_ready = (state_q == ST_IDLE);

  // ****************************************
  // cycle sequencer
  // ****************************************
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q     <= ST_IDLE;
      cnt_q       <= {CNT_W{1'b0}};
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= {DATA_W{1'b0}};
      o_mem_addr  <= {ADDR_W{1'b0}};
      o_mem_sel_n <= 1'b1;
      o_mem_oe_n  <= 1'b1;
      o_mem_we_n  <= 1'b1;
      o_mem_dq    <= {DATA_W{1'b0}};
      o_mem_dq_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_req_valid) begin
            // address moves only while select and strobe are high
            o_mem_addr  <= i_req_addr;
            o_mem_sel_n <= 1'b0;
            cnt_q       <= {CNT_W{1'b0}};
            if (i_req_write) begin
              // strobe and select fall together; enable stays high so bus is ours
              o_mem_we_n  <= 1'b0;
              o_mem_dq    <= i_req_wdata;
              o_mem_dq_oe <= 1'b1;
              state_q     <= ST_WR;
            end else begin
              o_mem_we_n <= 1'b1;
              o_mem_oe_n <= 1'b0;
              state_q    <= ST_RD;
            end
          end
        end
        ST_RD: begin
          cnt_q <= cnt_q + 8'h01;
          // sample only after select and enable access times both elapsed
          if (cnt_q + 8'h01 >= RD_LAST) begin
            o_rsp_rdata <= i_mem_dq;
            o_rsp_valid <= 1'b1;
            o_mem_sel_n <= 1'b1;
            o_mem_oe_n  <= 1'b1;
            cnt_q       <= {CNT_W{1'b0}};
            state_q     <= ST_RECOV;
          end
        end
        ST_WR: begin
          cnt_q <= cnt_q + 8'h01;
          // pulse covers select, address and width minima together
          if (cnt_q + 8'h01 >= WR_LAST) begin
            o_mem_we_n <= 1'b1;
            state_q    <= ST_WHOLD;
          end
        end
        ST_WHOLD: begin
          // one cycle after strobe rise: data and address held, then select rises
          o_mem_sel_n <= 1'b1;
          o_mem_dq_oe <= 1'b0;
          cnt_q       <= {CNT_W{1'b0}};
          state_q     <= ST_RECOV;
        end
        ST_RECOV: begin
          // gap lets the device float the bus and spaces cycles apart
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q + 8'h01 >= REC_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // asrc_host

// ### hw/asrc_consts.vh
// timing constants and widths for the asynchronous static memory host controller
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH

`define ASRC_CLK_PERIOD_NS   20
`define ASRC_ADDR_W          19
`define ASRC_DATA_W          8

// fast grade figures in ns; slow grade figures are not listed
`define ASRC_T_READ_CYCLE_NS    70
`define ASRC_T_OE_ACCESS_NS     35
`define ASRC_T_SEL_TO_END_NS    65
`define ASRC_T_ADDR_TO_END_NS   65
`define ASRC_T_WRITE_PULSE_NS   55
`define ASRC_T_WRITE_CYCLE_NS   70
`define ASRC_T_DATA_SETUP_NS    30
`define ASRC_T_RECOVERY_SEL_NS  15
`define ASRC_T_HOLD_SEL_NS      10
`define ASRC_T_RELEASE_NS       25

// least times round up to whole cycles
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)

`endif

// ### sim/asrc_mem_model.sv
// behavioural static memory on the far side of the host
`timescale 1ns/100ps
module asrc_mem_model (
  input wire [18:0] i_addr,
  input wire i_sel_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire [7:0] i_dq,
  input wire i_dq_oe,
  output wire [7:0] o_dq
);
  reg [7:0] mem [0:524287];
  reg [7:0] q = 8'h00;
  wire rd = !i_sel_n && !i_oe_n && i_we_n;
  wire drv;
  assign #(5,25) drv = rd;
  // old data spoils after the hold time, so early sampling fails
  always @(i_addr or rd) begin
    q <= #10 ~q;
    q <= #70 mem[i_addr];
  end
  assign o_dq = drv ? q : ~q;
  always @(posedge i_sel_n or posedge i_we_n)
    if ((i_sel_n ^ i_we_n) && i_dq_oe) mem[i_addr] <= i_dq;
endmodule // asrc_mem_model

// ### sim/asrc_host_chk.sv
// pin-level checks on the static memory host
`timescale 1ns/100ps
module asrc_host_chk (
  input wire i_core_clk,
  input wire i_rstn,
  input wire [18:0] o_mem_addr,
  input wire o_mem_sel_n,
  input wire o_mem_oe_n,
  input wire o_mem_we_n,
  input wire [7:0] o_mem_dq,
  input wire o_mem_dq_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_rd_we_hi: assert property (!o_mem_oe_n |-> o_mem_we_n)
    else $error("we low");
  a_rd_no_drv: assert property (!o_mem_oe_n |-> !o_mem_dq_oe)
    else $error("clash");
  a_sel_width: assert property ($fell(o_mem_sel_n) |-> !o_mem_sel_n[*4])
    else $error("cs");
  a_we_width: assert property ($fell(o_mem_we_n) |-> !o_mem_we_n[*3])
    else $error("we");
  a_dq_steady: assert property (!o_mem_we_n[*2] |-> $stable(o_mem_dq))
    else $error("dq");
  a_we_hold: assert property ($rose(o_mem_we_n) |-> o_mem_dq_oe)
    else $error("hold");
  a_addr_quiet: assert property ($changed(o_mem_addr) |-> $past(o_mem_sel_n | o_mem_we_n))
    else $error("addr");
  a_sel_recover: assert property ($rose(o_mem_sel_n) |-> o_mem_sel_n[*2])
    else $error("gap");
  c_read: cover property ($rose(o_mem_oe_n));
  c_write: cover property ($rose(o_mem_we_n));
  c_frozen: cover property (!o_mem_sel_n[*6]);
endmodule // asrc_host_chk
bind asrc_host asrc_host_chk asrc_host_chk_inst (.*);

// ### sim/asrc_host_tb.sv
// self-checking bench: host controller against the memory model
`timescale 1ns/100ps
module asrc_host_tb;
  reg clk = 0, rstn = 0, ce = 1, v = 0, w = 0;
  reg [18:0] a = 0;
  reg [7:0] d = 0;
  wire rdy, rv, sn, on, wn, oe;
  wire [7:0] rd, hq, mq;
  wire [18:0] ma;
  integer miscompares = 0, checked = 0, i, n;
  reg [27:0] rows [0:3];
  asrc_host asrc_host_inst (.i_core_clk(clk), .i_rstn(rstn), .i_clk_en(ce), .i_req_valid(v),
    .i_req_write(w), .i_req_addr(a), .i_req_wdata(d), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(rd), .o_mem_addr(ma), .o_mem_sel_n(sn), .o_mem_oe_n(on), .o_mem_we_n(wn),
    .i_mem_dq(oe ? hq : mq), .o_mem_dq(hq), .o_mem_dq_oe(oe));
  asrc_mem_model asrc_mem_model_inst (.i_addr(ma), .i_sel_n(sn), .i_oe_n(on), .i_we_n(wn),
    .i_dq(hq), .i_dq_oe(oe), .o_dq(mq));
  initial forever #10 clk = ~clk;
  task tick; begin @(posedge clk); #1; end endtask
  task cmp(input string nm, input [31:0] e, s); begin
    checked = checked + 1;
    if (e !== s) begin
      miscompares = miscompares + 1;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  end endtask
  task req(input x, input [18:0] ad, input [7:0] dd); begin
    w = x; a = ad; d = dd; v = 1; n = 0;
    while (rdy !== 1'b1 && n < 50) begin tick; n = n + 1; end
    if (n >= 50) miscompares = miscompares + 1;
    tick;
    v = 0;
  end endtask
  // a frozen clock enable stretches the wait but not the enabled count
  task rdc(input [18:0] ad, input [7:0] e, input integer f); begin
    req(0, ad, 8'h00);
    ce = (f == 0);
    repeat (f) tick;
    ce = 1; n = 0;
    while (rv !== 1'b1 && n < 20) begin tick; n = n + 1; end
    cmp("latency", 4, n);
    cmp("rdata", e, rd);
  end endtask
  task finish_test; begin
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  initial begin
    rows[0] = {1'b1, 19'h7ffff, 8'h5a};
    rows[1] = {1'b1, 19'h00000, 8'ha5};
    rows[2] = {1'b0, 19'h7ffff, 8'h5a};
    rows[3] = {1'b0, 19'h00000, 8'ha5};
    repeat (5) tick;
    cmp("reset pins", 5'h1f, {rdy, sn, on, wn, ~oe});
    rstn = 1;
    for (i = 0; i < 4; i = i + 1)
      if (rows[i][27]) req(1, rows[i][26:8], rows[i][7:0]);
      else rdc(rows[i][26:8], rows[i][7:0], 0);
    $display("table test done");
    req(1, 19'h00000, 8'hc3);
    rdc(19'h00000, 8'hc3, 3);
    $display("freeze test done");
    req(1, 19'h00001, 8'hff);
    tick;
    rstn = 0;
    #1 cmp("abort pins", 5'h1f, {rdy, sn, on, wn, ~oe});
    repeat (2) tick;
    rstn = 1;
    rdc(19'h7ffff, 8'h5a, 0);
    $display("abort test done");
    finish_test;
  end
  initial begin #100000; miscompares = miscompares + 1; finish_test; end
endmodule // asrc_host_tb
